// ==== logic/irxc_top.sv ====
// iso receive context start pointers, start gate and packet acceptance filter
`timescale 1ns/1ps
module irxc_top #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input  wire logic                  clk,            // 40 MHz clock
  input  wire logic                  rst,            // sync reset, active high
  input  wire logic                  s_awvalid,      // axi write address valid
  output logic                       s_awready,      // axi write address ready
  input  wire logic [15:0]           s_awaddr,       // axi write address
  input  wire logic                  s_wvalid,       // axi write data valid
  output logic                       s_wready,       // axi write data ready
  input  wire logic [31:0]           s_wdata,        // axi write data
  input  wire logic [3:0]            s_wstrb,        // axi byte strobes
  output logic                       s_bvalid,       // axi write response valid
  input  wire logic                  s_bready,       // axi write response ready
  output logic [1:0]                 s_bresp,        // axi write response
  input  wire logic                  s_arvalid,      // axi read address valid
  output logic                       s_arready,      // axi read address ready
  input  wire logic [15:0]           s_araddr,       // axi read address
  output logic                       s_rvalid,       // axi read data valid
  input  wire logic                  s_rready,       // axi read data ready
  output logic [31:0]                s_rdata,        // axi read data
  output logic [1:0]                 s_rresp,        // axi read response
  input  wire logic [31:0]           cycle_time,     // bus cycle timer value
  input  wire logic [7:0]            desc_wait_sync, // active descriptor wait is 11b
  input  wire logic                  pkt_valid,      // received packet offered
  output logic                       pkt_ready,      // packet taken
  input  wire irxc_pkg::irxc_pkt_s   pkt,            // received packet fields
  output logic                       fetch_valid,    // descriptor fetch request
  input  wire logic                  fetch_ready,    // fetch accepted
  output irxc_pkg::irxc_fetch_s      fetch,          // fetch address and count
  output logic                       rx_valid,       // accepted word available
  input  wire logic                  rx_ready,       // consumer takes word
  output irxc_pkg::irxc_word_s       rx              // accepted word and context
);
  typedef struct packed {
    logic [7:0][31:0]      cmdptr;
    logic [7:0][31:0]      match;
    logic [7:0]            run;
    logic [7:0]            gate;
    logic [7:0]            multi;
    logic [7:0]            active;
    logic [7:0]            pend;
    logic [7:0]            armed;
    logic [63:0]           chmask;
    logic                  lock;
    logic                  aw_held;
    logic [15:0]           aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  fvalid;
    irxc_pkg::irxc_fetch_s freq;
  } irxc_state_s;

  typedef enum {
    KIND_NONE,
    KIND_CMDPTR,
    KIND_MATCH,
    KIND_CTRL,
    KIND_MASK_HI,
    KIND_MASK_LO,
    KIND_LINK
  } irxc_kind_e;

  irxc_state_s s_q, s_d;
  logic        push;
  irxc_pkg::irxc_word_s push_word;
  logic        fifo_in_ready;

  // =====================================================================
  // helpers
  function automatic irxc_kind_e decode(input logic [15:0] a);
    logic [15:0] base;
    base = a & ~irxc_pkg::CTX_SEL_MASK;
    if (base == irxc_pkg::CMDPTR_BASE) begin
      decode = KIND_CMDPTR;
    end else if (base == irxc_pkg::MATCH_BASE) begin
      decode = KIND_MATCH;
    end else if (base == irxc_pkg::CTRL_BASE) begin
      decode = KIND_CTRL;
    end else if (a == irxc_pkg::CHMASK_HI) begin
      decode = KIND_MASK_HI;
    end else if (a == irxc_pkg::CHMASK_LO) begin
      decode = KIND_MASK_LO;
    end else if (a == irxc_pkg::LINKCTL) begin
      decode = KIND_LINK;
    end else begin
      decode = KIND_NONE;
    end
  endfunction

  function automatic logic [2:0] ctx_of(input logic [15:0] a);
    ctx_of = a[irxc_pkg::CTX_SEL_LSB +: 3];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~m) | (nv & m);
  endfunction

  // packet filter for one context
  function automatic logic ctx_accepts(input logic [31:0] m, input logic multi,
                                       input logic [63:0] mask, input logic wsync,
                                       input logic lock, input irxc_pkg::irxc_pkt_s p);
    logic chan_ok;
    logic tag_ok;
    logic sync_ok;
    logic filt;
    filt = m[irxc_pkg::MATCH_FILT_BIT] | lock;
    if (multi) begin
      chan_ok = mask[p.channel];
    end else begin
      chan_ok = (m[5:0] == p.channel);
    end
    tag_ok = m[irxc_pkg::MATCH_TAG_LSB + 32'(p.tag)];
    if ((p.tag == irxc_pkg::TAG_01) && filt && (p.sync[3:2] != 2'h0)) begin
      tag_ok = 1'b0;
    end // other tags use enables only
    sync_ok = !wsync || (p.sync == m[irxc_pkg::MATCH_SYNC_LSB +: 4]);
    ctx_accepts = chan_ok && tag_ok && sync_ok;
  endfunction

  // register read image
  function automatic logic [31:0] read_reg(input irxc_state_s s, input irxc_kind_e k,
                                           input logic [2:0] c);
    logic [31:0] v;
    v = irxc_pkg::REG_RESET;
    case (k)
      KIND_CMDPTR: v = s.cmdptr[c];
      KIND_MATCH: begin
        v = s.match[c] & irxc_pkg::MATCH_WMASK;
        v[irxc_pkg::MATCH_FILT_BIT] = s.match[c][irxc_pkg::MATCH_FILT_BIT] | s.lock;
      end
      KIND_CTRL: begin
        v[irxc_pkg::CTRL_GATE_BIT]   = s.gate[c];
        v[irxc_pkg::CTRL_MULTI_BIT]  = s.multi[c];
        v[irxc_pkg::CTRL_RUN_BIT]    = s.run[c];
        v[irxc_pkg::CTRL_ACTIVE_BIT] = s.active[c];
      end
      KIND_MASK_HI: v = s.chmask[63:32];
      KIND_MASK_LO: v = s.chmask[31:0];
      KIND_LINK: v[irxc_pkg::LINK_LOCK_BIT] = s.lock;
      default: v = irxc_pkg::REG_RESET;
    endcase
    read_reg = v;
  endfunction

  // =====================================================================
  // packet acceptance: lowest matching active context wins
  always_comb begin
    push      = 1'b0;
    push_word = '0;
    for (int i = irxc_pkg::NUM_CTX - 1; i >= 0; i--) begin
      if (s_q.active[i] && ctx_accepts(s_q.match[i], s_q.multi[i], s_q.chmask,
                                       desc_wait_sync[i], s_q.lock, pkt)) begin
        push          = pkt_valid;
        push_word.ctx = 3'(i);
      end
    end
    push_word.data = pkt.data;
  end

  // =====================================================================
  // next state
  always_comb begin
    irxc_kind_e  wk;
    irxc_kind_e  rk;
    logic [2:0]  wc;
    logic [31:0] nv;
    logic        found;
    wk    = KIND_NONE;
    rk    = KIND_NONE;
    wc    = 3'h0;
    nv    = irxc_pkg::REG_RESET;
    found = 1'b0;
    s_d   = s_q;

    // context start sequencing
    if (s_q.fvalid && fetch_ready) begin
      s_d.fvalid = 1'b0;
      s_d.armed[s_q.freq.ctx] = s_q.run[s_q.freq.ctx];
    end
    if (!s_q.fvalid) begin
      for (int i = irxc_pkg::NUM_CTX - 1; i >= 0; i--) begin
        if (s_q.pend[i]) begin
          found = 1'b1;
          wc    = 3'(i);
        end
      end
      if (found) begin
        s_d.fvalid    = 1'b1;
        s_d.pend[wc]  = 1'b0;
        s_d.freq.ctx  = wc;
        s_d.freq.program_start_location = s_q.cmdptr[wc][31:4];
        s_d.freq.count = s_q.cmdptr[wc][3:0];
      end
    end
    for (int i = 0; i < irxc_pkg::NUM_CTX; i++) begin
      if (s_q.armed[i]) begin
        // comparison uses two seconds bits above the cycle index
        if (!s_q.gate[i] || (cycle_time[irxc_pkg::TIMER_CMP_LSB +: irxc_pkg::CYC_CMP_W]
            == s_q.match[i][irxc_pkg::MATCH_CYC_LSB +: irxc_pkg::CYC_CMP_W])) begin
          s_d.active[i] = 1'b1;
          s_d.armed[i]  = 1'b0;
          s_d.gate[i]   = 1'b0;
        end
      end
    end

    // axi write channel
    if (s_q.awready && s_awvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_awaddr;
    end
    if (s_q.wready && s_wvalid) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_wdata;
      s_d.w_strb = s_wstrb;
    end
    if (s_q.bvalid && s_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      wk = decode(s_q.aw_addr);
      wc = ctx_of(s_q.aw_addr);
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = (wk == KIND_NONE) ? irxc_pkg::RESP_SLVERR : irxc_pkg::RESP_OKAY;
      case (wk)
        KIND_CMDPTR: begin
          s_d.cmdptr[wc] = merge(s_q.cmdptr[wc], s_q.w_data, s_q.w_strb, '1);
        end
        KIND_MATCH: begin
          nv = merge(s_q.match[wc], s_q.w_data, s_q.w_strb, irxc_pkg::MATCH_WMASK);
          if (s_q.lock) begin
            nv[irxc_pkg::MATCH_FILT_BIT] = 1'b1;
          end
          s_d.match[wc] = nv;
        end
        KIND_CTRL: begin
          nv = merge({2'h0, s_q.gate[wc], s_q.multi[wc], 12'h000, s_q.run[wc], 15'h0000},
                     s_q.w_data, s_q.w_strb, irxc_pkg::CTRL_WMASK);
          s_d.multi[wc] = nv[irxc_pkg::CTRL_MULTI_BIT];
          // a software set of the gate lands after any hardware clear
          s_d.gate[wc]  = nv[irxc_pkg::CTRL_GATE_BIT];
          s_d.run[wc]   = nv[irxc_pkg::CTRL_RUN_BIT];
          if (nv[irxc_pkg::CTRL_RUN_BIT] && !s_q.run[wc]) begin
            s_d.pend[wc] = 1'b1;
          end
          if (!nv[irxc_pkg::CTRL_RUN_BIT]) begin
            s_d.pend[wc]   = 1'b0;
            s_d.armed[wc]  = 1'b0;
            s_d.active[wc] = 1'b0;
          end
        end
        KIND_MASK_HI: s_d.chmask[63:32] = merge(s_q.chmask[63:32], s_q.w_data,
                                                s_q.w_strb, '1);
        KIND_MASK_LO: s_d.chmask[31:0] = merge(s_q.chmask[31:0], s_q.w_data,
                                               s_q.w_strb, '1);
        KIND_LINK: begin
          nv = merge(32'(s_q.lock) << irxc_pkg::LINK_LOCK_BIT, s_q.w_data, s_q.w_strb,
                     32'h1 << irxc_pkg::LINK_LOCK_BIT);
          s_d.lock = nv[irxc_pkg::LINK_LOCK_BIT];
        end
        default: s_d.bresp = irxc_pkg::RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready  = !s_d.w_held && !s_d.bvalid;

    // axi read channel
    if (s_q.rvalid && s_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_arvalid) begin
      rk = decode(s_araddr);
      s_d.rvalid = 1'b1;
      s_d.rdata  = read_reg(s_q, rk, ctx_of(s_araddr));
      s_d.rresp  = (rk == KIND_NONE) ? irxc_pkg::RESP_SLVERR : irxc_pkg::RESP_OKAY;
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // accepted word buffer
  irxc_fifo #(
    .WIDTH ($bits(irxc_pkg::irxc_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push && fifo_in_ready),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx)
  );

  assign pkt_ready   = fifo_in_ready;
  assign s_awready   = s_q.awready;
  assign s_wready    = s_q.wready;
  assign s_bvalid    = s_q.bvalid;
  assign s_bresp     = s_q.bresp;
  assign s_arready   = s_q.arready;
  assign s_rvalid    = s_q.rvalid;
  assign s_rdata     = s_q.rdata;
  assign s_rresp     = s_q.rresp;
  assign fetch_valid = s_q.fvalid;
  assign fetch       = s_q.freq;
endmodule // irxc_top

// ==== logic/irxc_pkg.sv ====
// package with constants and carrier types for the iso receive start and filter block
package irxc_pkg;
  // =====================================================================
  // geometry
  localparam int unsigned NUM_CTX     = 8;
  localparam int unsigned CTX_SEL_LSB = 5;
  localparam logic [15:0] CTX_SEL_MASK = 16'h00E0;
  // =====================================================================
  // register byte offsets (per-context registers: context 0; + 32 * n; channel mask and link control are single)
  localparam logic [15:0] CMDPTR_BASE = 16'h040C;
  localparam logic [15:0] MATCH_BASE  = 16'h410C;
  localparam logic [15:0] CTRL_BASE   = 16'h0400;
  localparam logic [15:0] CHMASK_HI   = 16'h0070;
  localparam logic [15:0] CHMASK_LO   = 16'h0078;
  localparam logic [15:0] LINKCTL     = 16'h00E0;
  // =====================================================================
  // field positions
  localparam int unsigned CTRL_GATE_BIT   = 29;
  localparam int unsigned CTRL_MULTI_BIT  = 28;
  localparam int unsigned CTRL_RUN_BIT    = 15;
  localparam int unsigned CTRL_ACTIVE_BIT = 10;
  localparam int unsigned LINK_LOCK_BIT   = 6;
  localparam int unsigned MATCH_TAG_LSB   = 28;
  localparam int unsigned MATCH_CYC_LSB   = 12;
  localparam int unsigned MATCH_SYNC_LSB  = 8;
  localparam int unsigned MATCH_FILT_BIT  = 6;
  localparam int unsigned TIMER_CMP_LSB   = 12;
  localparam int unsigned CYC_CMP_W       = 15;
  localparam logic [31:0] MATCH_WMASK     = 32'hF7FF_FF7F;
  localparam logic [31:0] CTRL_WMASK      = 32'h3000_8000;
  // =====================================================================
  // reset values and answers
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  TAG_01     = 2'h1;
  // =====================================================================
  // carriers
  typedef struct packed {
    logic [5:0]  channel;
    logic [1:0]  tag;
    logic [3:0]  sync;
    logic [31:0] data;
  } irxc_pkt_s;
  typedef struct packed {
    logic [2:0]  ctx;
    logic [31:0] data;
  } irxc_word_s;
  typedef struct packed {
    logic [27:0] program_start_location;
    logic [3:0]  count;
    logic [2:0]  ctx;
  } irxc_fetch_s;
endpackage

// ==== logic/irxc_fifo.sv ====
// fifo with registered read stage for accepted packet words
`timescale 1ns/1ps
module irxc_fifo #(
  parameter int unsigned WIDTH = 35,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,       // clock
  input  wire logic             rst,       // sync reset
  input  wire logic             in_valid,  // write offer
  output logic                  in_ready,  // room available
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // read word held
  input  wire logic             out_ready, // reader takes word
  output logic [WIDTH-1:0]      out_data   // read word
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        ov;
    logic [WIDTH-1:0]            od;
    logic                        ir;
  } irxc_fifo_s;
  irxc_fifo_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.ov && out_ready) begin
      s_d.ov = 1'b0;
    end
    // refill output stage from storage
    if ((!s_q.ov || out_ready) && (s_q.cnt != '0)) begin
      s_d.od  = s_q.mem[s_q.rp];
      s_d.ov  = 1'b1;
      s_d.rp  = s_q.rp + 1'b1;
      s_d.cnt = s_d.cnt - 1'b1;
    end
    if (in_valid && s_q.ir) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp  = s_q.wp + 1'b1;
      s_d.cnt = s_d.cnt + 1'b1;
    end
    s_d.ir = (s_d.cnt < (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready  = s_q.ir;
  assign out_valid = s_q.ov;
  assign out_data  = s_q.od;
endmodule // irxc_fifo

// ==== sim/irxc_top_chk.sv ====
// port timing and register read checks for irxc_top
`timescale 1ns/1ps
module irxc_top_chk #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic                  clk,         // clock
  input wire logic                  rst,         // sync reset
  input wire logic                  s_awvalid,   // write address valid
  input wire logic                  s_awready,   // write address ready
  input wire logic                  s_wvalid,    // write data valid
  input wire logic                  s_wready,    // write data ready
  input wire logic                  s_bvalid,    // write response valid
  input wire logic                  s_arvalid,   // read address valid
  input wire logic                  s_arready,   // read address ready
  input wire logic [15:0]           s_araddr,    // read address
  input wire logic                  s_rvalid,    // read data valid
  input wire logic [31:0]           s_rdata,     // read data
  input wire logic [1:0]            s_rresp,     // read response
  input wire logic                  pkt_ready,   // packet taken
  input wire logic                  fetch_valid, // fetch request
  input wire logic                  fetch_ready, // fetch accepted
  input wire irxc_pkg::irxc_fetch_s fetch,       // fetch fields
  input wire logic                  rx_valid,    // accepted word valid
  input wire logic                  rx_ready,    // accepted word taken
  input wire irxc_pkg::irxc_word_s  rx           // accepted word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // =====================================================================
  // read target tracking
  logic rd_match_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_match_q <= 1'b0;
    end else if (s_arvalid && s_arready) begin
      rd_match_q <= (s_araddr[15:8] == 8'h41) && (s_araddr[4:0] == 5'h0C);
    end
  end
  // =====================================================================
  // assertions
  a_fetch_hold: assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch))
    else $error("fetch request dropped or changed before acceptance");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx))
    else $error("accepted word dropped or changed before taken");
  a_rsv_zero: assert property (s_rvalid && rd_match_q |-> !s_rdata[27] && !s_rdata[7])
    else $error("match register reserved bit read nonzero");
  a_match_mapped: assert property (s_rvalid && rd_match_q |-> s_rresp == irxc_pkg::RESP_OKAY)
    else $error("match register read refused");
  a_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
    else $error("read answer not one cycle after address");
  a_wr_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response not two cycles after address and data");
  a_b_blocks: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("new write accepted while response pending");
  a_full_has_data: assert property (!pkt_ready && !$past(rst) |-> rx_valid)
    else $error("packet path refused with nothing buffered");
endmodule // irxc_top_chk

bind irxc_top irxc_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk(clk), .rst(rst), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rdata(s_rdata), .s_rresp(s_rresp),
  .pkt_ready(pkt_ready), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .fetch(fetch),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx(rx));

// ==== sim/irxc_link_src.sv ====
// link layer model offering received iso packets
`timescale 1ns/1ps
module irxc_link_src (
  input wire logic            clk,       // clock
  output logic                pkt_valid, // packet offered
  input wire logic            pkt_ready, // packet taken
  output irxc_pkg::irxc_pkt_s pkt        // packet fields
);
  initial begin
    pkt_valid = 1'b0;
    pkt = '0;
  end
  // offer one packet, hold it until taken or the wait runs out
  task automatic send(input irxc_pkg::irxc_pkt_s p, output bit ok);
    int n;
    ok = 1'b0;
    pkt <= p;
    pkt_valid <= 1'b1;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      ok = pkt_ready;
    end
    pkt_valid <= 1'b0;
    // released bus shows the inverse, not a stale copy
    pkt <= ~p;
  endtask
endmodule // irxc_link_src

// ==== sim/tb_iso_rx_context_start_and_filter.sv ====
// self-checking bench for the iso receive start and filter block
`timescale 1ns/1ps
module tb_iso_rx_context_start_and_filter;
  localparam int DEPTH = 16;
  logic                  clk, rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic                  s_bready, s_arvalid, s_arready, s_rvalid, s_rready, pkt_valid;
  logic                  pkt_ready, fetch_valid, fetch_ready, rx_valid, rx_ready, lk, e3, e5;
  logic [15:0]           s_awaddr, s_araddr;
  logic [31:0]           s_wdata, s_rdata, cycle_time, m3, m5, rd;
  logic [31:0]           v [8];
  logic [31:0]           q [$];
  logic [3:0]            s_wstrb;
  logic [1:0]            s_bresp, s_rresp, rs;
  logic [7:0]            desc_wait_sync;
  logic [63:0]           cmask;
  irxc_pkg::irxc_pkt_s   pkt, p;
  irxc_pkg::irxc_fetch_s fetch;
  irxc_pkg::irxc_word_s  rx;
  int                    mismatches, samples_checked, n;
  bit                    ok;

  always #12.5 clk = ~clk;
  irxc_top #(.FIFO_DEPTH(DEPTH)) dut (
    .clk(clk), .rst(rst), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .cycle_time(cycle_time),
    .desc_wait_sync(desc_wait_sync), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .fetch(fetch),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx(rx));

  irxc_link_src u_src (.clk(clk), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt));

  // =====================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask

  function automatic logic [15:0] ad(input logic [15:0] b, input int i);
    return b + 16'(i * 32);
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int  k;
    logic ta, td;
    ta = 1'b0;
    td = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    for (k = 0; !(ta && td); k++) begin
      @(posedge clk);
      if (k > 50) hang();
      if (!ta && s_awready) begin
        ta = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!td && s_wready) begin
        td = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) hang();
    end while (!s_bvalid);
    rs = s_bresp;
  endtask

  task automatic rdr(input logic [15:0] a);
    int k;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) hang();
    end while (!s_arready);
    s_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      k++;
      if (k > 100) hang();
    end while (!s_rvalid);
    rd = s_rdata;
    rs = s_rresp;
  endtask

  task automatic fetch_do(input int c, input logic [31:0] ptr);
    int k;
    for (k = 0; !fetch_valid; k++) begin
      @(posedge clk);
      if (k > 50) hang();
    end
    // stall to see the request held
    repeat (3) @(posedge clk);
    chk(32'(fetch.program_start_location), {4'h0, ptr[31:4]});
    chk(32'(fetch.count), 32'(ptr[3:0]));
    chk(32'(fetch.ctx), 32'(c));
    fetch_ready <= 1'b1;
    @(posedge clk);
    fetch_ready <= 1'b0;
  endtask

  function automatic logic acc(input logic [31:0] m, input logic mc, input logic ws,
                               input irxc_pkg::irxc_pkt_s k);
    logic ch;
    ch = mc ? cmask[k.channel] : (k.channel == m[5:0]);
    return ch && m[28 + k.tag] && !(k.tag == 2'h1 && (m[6] || lk) && k.sync[3:2] != 2'h0)
           && !(ws && k.sync != m[11:8]);
  endfunction

  // =====================================================================
  // main sequence
  initial begin
    {clk, s_awvalid, s_wvalid, s_arvalid, fetch_ready, rx_ready, lk} = '0;
    {s_awaddr, s_araddr, s_wdata, cycle_time, desc_wait_sync} = '0;
    {rst, s_bready, s_rready} = 3'h7;
    s_wstrb = 4'hF;
    void'($urandom(32'h5CB39C3E));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      v[i] = ($urandom & 32'hFFFF_FFF0) | 32'($urandom_range(8, 0));
      wr(ad(irxc_pkg::CMDPTR_BASE, i), v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      rdr(ad(irxc_pkg::CMDPTR_BASE, i));
      chk(rd, v[i]);
    end
    wr(ad(irxc_pkg::MATCH_BASE, 0), 32'hFFFF_FFFF);
    rdr(ad(irxc_pkg::MATCH_BASE, 0));
    chk(rd, 32'hF7FF_FF7F);
    rdr(16'h0FF0);
    chk({rd[29:0], rs}, {30'h0, irxc_pkg::RESP_SLVERR});
    wr(16'h0FF0, $urandom);
    chk(rs, irxc_pkg::RESP_SLVERR);
    wr(irxc_pkg::LINKCTL, 32'h0000_0040);
    wr(ad(irxc_pkg::MATCH_BASE, 1), 32'h0);
    rdr(ad(irxc_pkg::MATCH_BASE, 1));
    chk(rd, 32'h0000_0040);
    wr(irxc_pkg::LINKCTL, 32'h0);
    $display("test registers done");
    m3 = $urandom & 32'hF7FF_FF7F;
    m5 = ($urandom & 32'hF7FF_FF7F) | 32'h0000_1000;
    cmask = {$urandom, $urandom};
    wr(ad(irxc_pkg::MATCH_BASE, 3), m3);
    wr(ad(irxc_pkg::MATCH_BASE, 5), m5);
    wr(irxc_pkg::CHMASK_HI, cmask[63:32]);
    wr(irxc_pkg::CHMASK_LO, cmask[31:0]);
    wr(ad(irxc_pkg::CTRL_BASE, 3), 32'h0000_8000);
    fetch_do(3, v[3]);
    wr(ad(irxc_pkg::CTRL_BASE, 5), 32'h3000_8000);
    fetch_do(5, v[5]);
    repeat (4) @(posedge clk);
    rdr(ad(irxc_pkg::CTRL_BASE, 5));
    chk(rd, 32'h3000_8000);
    rdr(ad(irxc_pkg::CTRL_BASE, 3));
    chk(rd, 32'h0000_8400);
    cycle_time <= ($urandom & 32'hF800_0FFF) | {5'h0, m5[26:12], 12'h0};
    repeat (3) @(posedge clk);
    rdr(ad(irxc_pkg::CTRL_BASE, 5));
    chk(rd, 32'h1000_8400);
    $display("test start done");
    for (int i = 0; i < 60; i++) begin
      if (i == 30) begin
        wr(irxc_pkg::LINKCTL, 32'h0000_0040);
        lk = 1'b1;
      end
      p = {6'($urandom), 2'($urandom), 4'($urandom), $urandom};
      if ($urandom_range(1, 0)) p.channel = m3[5:0];
      if ($urandom_range(1, 0)) p.sync = m3[11:8];
      desc_wait_sync <= 8'($urandom);
      @(posedge clk);
      e3 = acc(m3, 1'b0, desc_wait_sync[3], p);
      e5 = acc(m5, 1'b1, desc_wait_sync[5], p);
      u_src.send(p, ok);
      for (n = 0; n < 5 && !rx_valid; n++) @(posedge clk);
      chk(rx_valid, e3 | e5);
      if (rx_valid) begin
        chk(32'(rx.ctx), e3 ? 32'h3 : 32'h5);
        chk(rx.data, p.data);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
      end
    end
    $display("test filter done");
    desc_wait_sync <= 8'h0;
    wr(ad(irxc_pkg::MATCH_BASE, 3), 32'h1000_0000 | {26'h0, m3[5:0]});
    for (int i = 0; i < DEPTH + 4; i++) begin
      p = {m3[5:0], 6'h0, $urandom};
      u_src.send(p, ok);
      if (!ok) break;
      q.push_back(p.data);
      @(posedge clk);
    end
    chk(q.size(), DEPTH + 1);
    rx_ready <= 1'b1;
    for (n = 0; n < 80 && q.size() > 0; n++) begin
      @(posedge clk);
      if (rx_valid) chk(rx.data, q.pop_front());
    end
    chk(q.size(), 0);
    rx_ready <= 1'b0;
    $display("test fifo done");
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    hang();
  end
endmodule // tb_iso_rx_context_start_and_filter
